// >>> adc_result_fifo_readback_status.sv
// result fifo with serial burst readback, ready signalling, status byte and crc
//
// Functional notes
// - burst read opens with 16 command clocks
// - sample is 24 clocks, 32 with tag
// - converter writes held off during readback
// - dout shows ready: high busy, low readable
// - watermark mode: ready high until watermark reached
// - streaming mode: ready pulses busy per write
// - tag: reserved, limit, level, drained, input index
// - tag stored only while tag append enabled
// - drained tag marks last stored sample read
// - level flag set while count at watermark
// - limit tag per sample, enabled input only
// - status byte sent during count byte
// - drained status: last read or empty read
// - lost flag on dropped or overwritten result
// - limit status flags sticky until emptied/cleared
// - read during write: error, zero data
// - write waits one conversion, else error
// - crc only with tag on, status off
// - crc after each watermark block of samples
// - crc polynomial fixed, seeded all ones
// - interrupt is or of enabled conditions
// - watermark interrupt while count at watermark
// - read command 0x7d plus count, 0 means 256
// - streaming mode overwrites oldest when full
`timescale 1ns/1ps
`include "fifo_rb_defines.svh"
module adc_result_fifo_readback_status #(
  parameter int DEPTH = 256,
  parameter int INPUTS = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic dout,
  output logic dout_oe,
  input wire logic fifo_en,
  input wire logic stream_mode,
  input wire logic tag_append_en,
  input wire logic state_append_en,
  input wire logic crc_en,
  input wire logic [7:0] watermark,
  input wire logic [6:0] int_enable,
  input wire logic master_err,
  input wire logic fifo_clear,
  input wire logic conv_valid,
  input wire fifo_rb_pkg::conv_t conv,
  input wire logic [INPUTS-1:0] input_limit_enable,
  input wire logic [11:0] upper_limit_value,
  input wire logic [11:0] lower_limit_value,
  output fifo_rb_pkg::status_t queue_state,
  output logic fifo_int
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [3:0] BUSY_CYC = 4'(`WR_BUSY_CYC);

  typedef struct packed {
    fifo_rb_pkg::entry_t [DEPTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    fifo_rb_pkg::status_t stat;
    logic pend;
    fifo_rb_pkg::conv_t pend_c;
    logic [3:0] busy;
    fifo_rb_pkg::conv_t wbuf;
    logic owned;
    logic first;
    logic ack;
    logic [2:0] req_s;
    logic [2:0] cs_s;
    fifo_rb_pkg::xfer_t xf;
    logic rdy;
    logic irq;
  } core_t;

  localparam core_t CORE_RST = '{
    stat: fifo_rb_pkg::status_t'(`QUEUE_STATE_RST),
    first: 1'b1,
    default: '0
  };
  localparam fifo_rb_pkg::link_t LINK_RST = '{
    phase: fifo_rb_pkg::PH_CMD,
    crc: `CRC_SEED,
    default: '0
  };

  core_t q, n;
  fifo_rb_pkg::link_t lk_q, l;
  logic [8:0] wm_n;
  logic [1:0] lim;
  logic [AW:0] cnt_after;
  logic cs_idle;
  logic req_ev;
  logic ack_ok;
  logic crc_bit;
  logic [15:0] crc_nxt;
  logic [7:0] cmd_now;

  // watermark field to entries, 0 meaning a full fifo
  function automatic logic [8:0] wm_entries(input logic [7:0] wm);
    return (wm == 8'h00) ? `WM_ZERO_ENTRIES : {1'b0, wm};
  endfunction

  // {above, below} for one result, gated by its input's enable
  function automatic logic [1:0] limit_check(input fifo_rb_pkg::conv_t c);
    logic en;
    logic [11:0] top;
    en = input_limit_enable[c.source_input_index];
    top = c.data[`LIMIT_MSB:`LIMIT_LSB];
    return {en && (top > upper_limit_value), en && (top < lower_limit_value)};
  endfunction

  // next sample onto the shifter; asks for the one after if any remain
  function automatic fifo_rb_pkg::link_t load_sample(input fifo_rb_pkg::link_t s,
                                                      input fifo_rb_pkg::xfer_t x, input logic ok);
    fifo_rb_pkg::link_t r;
    r = s;
    r.bcnt = 5'h00;
    r.phase = fifo_rb_pkg::PH_DATA;
    // tag bits go out only when appended
    r.sh = !ok ? 32'h0000_0000 : (s.tag_en ? x.word : {x.word.data, 8'h00});
    r.left = s.left - 9'h001;
    if (ok && s.left > 9'h001) begin
      r.req = ~s.req;
    end
    return r;
  endfunction

  // ---------------- core clock: storage, flags, ready ----------------

  always_comb begin
    n = q;
    cnt_after = q.count;
    wm_n = wm_entries(watermark);
    lim = limit_check(q.wbuf);
    n.req_s = {q.req_s[1:0], lk_q.req};
    n.cs_s = {q.cs_s[1:0], cs_n};
    cs_idle = q.cs_s[2] & q.cs_s[1];
    req_ev = (q.req_s[2] == q.req_s[1]) && (q.req_s[2] != q.ack);
    n.stat.master_err = master_err;

    // flush first, so events of the same cycle still land
    if (fifo_clear) begin
      n.count = '0;
      n.wr_ptr = '0;
      n.rd_ptr = '0;
      n.stat.lost = 1'b0;
      n.stat.upper_limit_flag = 1'b0;
      n.stat.lower_limit_flag = 1'b0;
      n.stat.write_err = 1'b0;
      n.stat.read_err = 1'b0;
      n.stat.drained = 1'b1;
    end

    // serial side requests: the first of a frame is a status snapshot, the rest are pops
    if (cs_idle) begin
      n.ack = 1'b0;
      n.first = 1'b1;
      n.owned = 1'b0;
    end else if (req_ev) begin
      n.ack = ~q.ack;
      if (q.first) begin
        n.first = 1'b0;
        n.xf.status = n.stat;
        n.xf.tag_en = tag_append_en;
        n.xf.stat_en = state_append_en;
        // crc only for tag on, status off
        n.xf.crc_on = crc_en && tag_append_en && !state_append_en;
        n.xf.wm = wm_n;
      end else begin
        n.owned = 1'b1;
        n.xf.word = '0;
        if (q.busy != 4'h0) begin
          n.stat.read_err = 1'b1;
        end else if (n.count == '0) begin
          n.stat.drained = 1'b1;
          n.xf.word.tag.drained = q.xf.tag_en;
        end else begin
          n.xf.word = q.mem[n.rd_ptr];
          // last stored sample carries drained tag
          n.xf.word.tag.drained = q.xf.tag_en && (n.count == (AW+1)'(1));
          n.rd_ptr = n.rd_ptr + 1'b1;
          n.count = n.count - 1'b1;
          n.stat.read_err = 1'b0;
          if (n.count == '0) begin
            n.stat.drained = 1'b1;
            n.stat.lost = 1'b0;
            n.stat.upper_limit_flag = 1'b0;
            n.stat.lower_limit_flag = 1'b0;
            n.stat.write_err = 1'b0;
          end
        end
      end
    end

    // pending write waits while the host owns the fifo
    if (q.pend && !q.owned && q.busy == 4'h0) begin
      n.busy = BUSY_CYC;
      n.wbuf = q.pend_c;
      n.pend = 1'b0;
    end else if (q.busy != 4'h0) begin
      n.busy = q.busy - 4'h1;
    end

    // a second result while one still waits: the older one is dropped
    if (conv_valid) begin
      if (n.pend) begin
        n.stat.write_err = 1'b1;
        n.stat.lost = 1'b1;
      end
      n.pend = 1'b1;
      n.pend_c = conv;
    end

    // commit in the last busy cycle
    if (q.busy == 4'h1) begin
      if (!stream_mode && n.count >= wm_n) begin
        n.stat.write_err = 1'b1;
        n.stat.lost = 1'b1;
      end else begin
        if (n.count == (AW+1)'(DEPTH)) begin
          n.rd_ptr = n.rd_ptr + 1'b1;
          n.stat.lost = 1'b1;
          cnt_after = n.count;
        end else begin
          cnt_after = n.count + 1'b1;
        end
        n.mem[n.wr_ptr].data = q.wbuf.data;
        n.mem[n.wr_ptr].tag.reserved = 1'b0;
        n.mem[n.wr_ptr].tag.limit_hit = |lim;
        // level tagged at or above watermark
        n.mem[n.wr_ptr].tag.level = cnt_after >= wm_n;
        n.mem[n.wr_ptr].tag.drained = 1'b0;
        n.mem[n.wr_ptr].tag.source_input_index = q.wbuf.source_input_index;
        // tag removed when append is off
        if (!tag_append_en) begin
          n.mem[n.wr_ptr].tag = '0;
        end
        n.wr_ptr = n.wr_ptr + 1'b1;
        n.count = cnt_after;
        n.stat.drained = 1'b0;
        n.stat.upper_limit_flag = n.stat.upper_limit_flag | lim[1];
        n.stat.lower_limit_flag = n.stat.lower_limit_flag | lim[0];
      end
    end

    n.stat.level = n.count >= wm_n;
    // ready high while busy, low when readable
    n.rdy = fifo_en && ((n.busy != 4'h0) || (!stream_mode && n.count < wm_n));
    n.irq = |(int_enable & n.stat[6:0]);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  // ---------------- serial clock: command, shifter, crc ----------------

  // one serial crc step per frame bit
  crc16_serial_step crc_step (
    .crc_cur(lk_q.crc),
    .bit_in(crc_bit),
    .crc_next(crc_nxt)
  );

  always_comb begin
    l = lk_q;
    l.ack_s = {lk_q.ack_s[1:0], q.ack};
    ack_ok = (lk_q.ack_s[2] == lk_q.ack_s[1]) && (lk_q.ack_s[2] == lk_q.req);
    crc_bit = (lk_q.phase == fifo_rb_pkg::PH_DATA) ? lk_q.sh[31] : mosi;
    cmd_now = {lk_q.cmd[6:0], mosi};
    l.sh = {lk_q.sh[30:0], 1'b0};
    l.bcnt = lk_q.bcnt + 5'h01;
    // first crc spans command, count and data
    if (lk_q.phase != fifo_rb_pkg::PH_CRC && lk_q.phase != fifo_rb_pkg::PH_DONE) begin
      l.crc = crc_nxt;
    end
    unique case (lk_q.phase)
      fifo_rb_pkg::PH_CMD: begin
        l.cmd = cmd_now;
        // status snapshot asked for at once, it must be back by the count byte
        if (lk_q.bcnt == 5'h00) begin
          l.req = ~lk_q.req;
        end
        if (lk_q.bcnt == `BYTE_LAST) begin
          // command byte done, count byte follows
          l.bcnt = 5'h00;
          l.phase = fifo_rb_pkg::PH_CNT;
          l.tag_en = q.xf.tag_en;
          l.crc_on = q.xf.crc_on;
          l.wm = q.xf.wm;
          // only the fifo read command pops
          l.is_fifo = ack_ok && (cmd_now == `CMD_FIFO_RD);
          if (l.is_fifo) begin
            l.req = ~lk_q.req;
          end
          if (ack_ok && (cmd_now == `CMD_STAT_RD || (l.is_fifo && q.xf.stat_en))) begin
            l.sh = {q.xf.status, 24'h00_0000};
          end
          if (cmd_now != `CMD_FIFO_RD && cmd_now != `CMD_STAT_RD) begin
            l.phase = fifo_rb_pkg::PH_DONE;
          end
        end
      end
      fifo_rb_pkg::PH_CNT: begin
        l.cnt = {lk_q.cnt[6:0], mosi};
        if (lk_q.bcnt == `BYTE_LAST) begin
          l.phase = fifo_rb_pkg::PH_DONE;
          if (lk_q.is_fifo) begin
            l.left = (l.cnt == 8'h00) ? 9'h100 : {1'b0, l.cnt};
            l.blk = 9'h000;
            l = load_sample(l, q.xf, ack_ok);
          end
        end
      end
      fifo_rb_pkg::PH_DATA: begin
        // 24 or 32 clocks per sample
        if (lk_q.bcnt == (lk_q.tag_en ? `SAMPLE_LAST_TAG : `SAMPLE_LAST_NOTAG)) begin
          l.blk = lk_q.blk + 9'h001;
          if (lk_q.crc_on && l.blk == lk_q.wm) begin
            l.phase = fifo_rb_pkg::PH_CRC;
            l.bcnt = 5'h00;
            l.sh = {crc_nxt, 16'h0000};
            l.crc = `CRC_SEED;
            l.blk = 9'h000;
          end else if (lk_q.left == 9'h000) begin
            l.phase = fifo_rb_pkg::PH_DONE;
          end else begin
            l = load_sample(l, q.xf, ack_ok);
          end
        end
      end
      fifo_rb_pkg::PH_CRC: begin
        if (lk_q.bcnt == `CRC_LAST) begin
          if (lk_q.left == 9'h000) begin
            l.phase = fifo_rb_pkg::PH_DONE;
          end else begin
            l = load_sample(l, q.xf, ack_ok);
          end
        end
      end
      fifo_rb_pkg::PH_DONE: begin
        l.bcnt = lk_q.bcnt;
      end
    endcase
  end

  // chip select high ends the frame; the link clock may stop right after
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_q <= LINK_RST;
    end else begin
      lk_q <= l;
    end
  end

  // ready rides on dout between frames; mux is a pin-level share, not a crossing
  assign dout = cs_n ? q.rdy : lk_q.sh[31];
  assign dout_oe = fifo_en | ~cs_n;
  assign queue_state = q.stat;
  assign fifo_int = q.irq;
endmodule

// >>> crc16_serial_step.sv
// one msb-first step of the readback crc
`timescale 1ns/1ps
`include "fifo_rb_defines.svh"
module crc16_serial_step (
  input wire logic [15:0] crc_cur,
  input wire logic bit_in,
  output logic [15:0] crc_next
);
  logic feedback;

  // shift left, fold in the polynomial when the outgoing bit differs
  always_comb begin
    feedback = crc_cur[15] ^ bit_in;
    crc_next = {crc_cur[14:0], 1'b0} ^ (feedback ? `CRC_POLY : 16'h0000);
  end
endmodule

// >>> fifo_rb_defines.svh
// offsets, field positions, reset values and timing counts of the result fifo readback
`ifndef FIFO_RB_DEFINES_SVH
`define FIFO_RB_DEFINES_SVH

// status register and its reset value
`define QUEUE_STATE_OFS 8'h3b
`define QUEUE_STATE_RST 8'h01

// serial commands: fifo burst read, and a plain read of the status register
`define CMD_RD_BIT 8'h40
`define CMD_FIFO_RD 8'h7d
`define CMD_STAT_RD (`CMD_RD_BIT | `QUEUE_STATE_OFS)

// frame lengths in sclk bits (CMD_BITS a count, the others the last index of each field)
`define CMD_BITS 16
`define BYTE_LAST 5'h07
`define SAMPLE_LAST_NOTAG 5'h17
`define SAMPLE_LAST_TAG 5'h1f
`define CRC_LAST 5'h0f

// readback crc
`define CRC_SEED 16'hffff
`define CRC_POLY 16'ha2eb

// watermark 0 stands for a full fifo
`define WM_ZERO_ENTRIES 9'h100

// interrupt enables after reset: only the watermark source
`define INT_EN_RST 7'h02

// limit comparison looks at the upper result bits
`define LIMIT_MSB 23
`define LIMIT_LSB 12

// length of the busy window around one converter write
`define CLK_PERIOD_NS 20
`define WR_BUSY_NS 160
`define WR_BUSY_CYC ((`WR_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> fifo_rb_pkg.sv
// types shared by the result fifo readback block
package fifo_rb_pkg;

  typedef enum logic [4:0] {
    PH_CMD  = 5'h01,
    PH_CNT  = 5'h02,
    PH_DATA = 5'h04,
    PH_CRC  = 5'h08,
    PH_DONE = 5'h10
  } phase_t;

  typedef struct packed {
    logic master_err;
    logic write_err;
    logic read_err;
    logic upper_limit_flag;
    logic lower_limit_flag;
    logic lost;
    logic level;
    logic drained;
  } status_t;

  typedef struct packed {
    logic reserved;
    logic limit_hit;
    logic level;
    logic drained;
    logic [3:0] source_input_index;
  } tag_t;

  typedef struct packed {
    logic [23:0] data;
    logic [3:0] source_input_index;
  } conv_t;

  typedef struct packed {
    logic [23:0] data;
    tag_t tag;
  } entry_t;

  // word handed from the core clock to the serial clock
  typedef struct packed {
    status_t status;
    logic tag_en;
    logic stat_en;
    logic crc_on;
    logic [8:0] wm;
    entry_t word;
  } xfer_t;

  // all state on the serial clock
  typedef struct packed {
    phase_t phase;
    logic [4:0] bcnt;
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [8:0] left;
    logic [8:0] blk;
    logic [31:0] sh;
    logic [15:0] crc;
    logic req;
    logic [2:0] ack_s;
    logic tag_en;
    logic crc_on;
    logic [8:0] wm;
    logic is_fifo;
  } link_t;

endpackage

// >>> fifo_rb_props.sv
// assertion checker for the result fifo readback block
`timescale 1ns/1ps
module fifo_rb_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic fifo_en,
  input wire logic stream_mode,
  input wire logic master_err,
  input wire logic fifo_clear,
  input wire logic conv_valid,
  input wire logic [6:0] int_enable,
  input wire fifo_rb_pkg::status_t queue_state,
  input wire logic fifo_int
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // host idle long enough for the core to have seen it
  sequence idle8;
    cs_n [*8];
  endsequence

  // a conversion offered while the host is away
  sequence conv_free;
    conv_valid && cs_n;
  endsequence

  // consecutive core cycles with the host away; a counter keeps long idle spans out of the properties
  logic [3:0] idle_run;
  always_ff @(posedge clk) begin
    if (reset || !cs_n) begin
      idle_run <= 4'h0;
    end else if (idle_run != 4'hf) begin
      idle_run <= idle_run + 4'h1;
    end
  end

  // the interrupt flop samples the enables with the same next status that the status flop takes
  int_or_a: assert property (!$past(reset) |-> fifo_int == |($past(int_enable) & queue_state[6:0]))
    else $error("interrupt differs from enabled flags");
  master_copy_a: assert property (master_err [*3] |-> queue_state.master_err)
    else $error("master error not copied");
  pin_enable_a: assert property (dout_oe == (fifo_en || !cs_n))
    else $error("dout enable wrong");
  ready_wait_a: assert property ((fifo_en && !stream_mode && cs_n && !queue_state.level) [*3] |-> dout)
    else $error("ready low below watermark");
  busy_pulse_a: assert property (conv_free ##0 (stream_mode && fifo_en) ##1 cs_n [*4] |-> dout)
    else $error("no busy during write");
  drained_clear_a: assert property (conv_free ##0 queue_state.drained ##10 (cs_n && idle_run >= 4'h9) |=> !queue_state.drained)
    else $error("drained kept after write");
  lost_hold_a: assert property (idle8 ##1 (queue_state.lost && cs_n && !fifo_clear) |=> queue_state.lost)
    else $error("lost flag dropped");
  clear_flags_a: assert property (fifo_clear |-> ##[1:2] !queue_state.lost && !queue_state.write_err)
    else $error("clear left error flags");
  full_drop_a: assert property (conv_free ##0 (!stream_mode && queue_state.level) |-> ##[1:12] queue_state.write_err)
    else $error("drop not flagged");
endmodule

bind adc_result_fifo_readback_status fifo_rb_props u_props (
  .clk(clk), .reset(reset), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .fifo_en(fifo_en),
  .stream_mode(stream_mode), .master_err(master_err), .fifo_clear(fifo_clear), .conv_valid(conv_valid),
  .int_enable(int_enable), .queue_state(queue_state), .fifo_int(fifo_int)
);

// >>> host_spi_model.sv
// host model: serial master that reads the result fifo
`timescale 1ns/1ps
module host_spi_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic dout
);
  logic [0:95] rx;

  // clock stands low and select high outside frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx = '0;
  end

  // one frame; dout is taken just before each rising edge
  task automatic frame(input logic [7:0] cmd, input logic [7:0] n, input int nb);
    logic [15:0] tx;
    tx = {cmd, n};
    // odd offset keeps the link edges away from the core clock edges
    #163;
    cs_n = 1'b0;
    // command byte and count lead the frame
    for (int k = 0; k < nb; k++) begin
      mosi = (k < 16) ? tx[15 - k] : 1'b0;
      #80;
      rx[k] = dout;
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
    end
    #80;
    cs_n = 1'b1;
    mosi = ~mosi; // released line must not keep its last level
    #160;
  endtask
endmodule

// >>> test_adc_result_fifo_readback_status.sv
// self-checking bench for the result fifo readback block
`timescale 1ns/1ps
`include "fifo_rb_defines.svh"
module test_adc_result_fifo_readback_status;
  logic clk, reset, sclk, cs_n, mosi, dout, dout_oe, fifo_en, stream_mode, tag_append_en;
  logic state_append_en, crc_en, master_err, fifo_clear, conv_valid, fifo_int;
  logic [7:0] watermark;
  logic [6:0] int_enable;
  logic [15:0] input_limit_enable;
  logic [11:0] upper_limit_value, lower_limit_value;
  fifo_rb_pkg::conv_t conv;
  fifo_rb_pkg::status_t queue_state;
  int n_fail, compares;

  adc_result_fifo_readback_status DUT (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .dout(dout), .dout_oe(dout_oe),
    .fifo_en(fifo_en), .stream_mode(stream_mode), .tag_append_en(tag_append_en),
    .state_append_en(state_append_en), .crc_en(crc_en), .watermark(watermark), .int_enable(int_enable),
    .master_err(master_err), .fifo_clear(fifo_clear), .conv_valid(conv_valid), .conv(conv),
    .input_limit_enable(input_limit_enable), .upper_limit_value(upper_limit_value),
    .lower_limit_value(lower_limit_value), .queue_state(queue_state), .fifo_int(fifo_int)
  );
  host_spi_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .dout(dout));

  // core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard
  initial begin
    #1ms;
    n_fail++;
    finish_test;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one conversion, then room for the busy window and status update
  task automatic put(input logic [23:0] d, input logic [3:0] idx);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv <= {d, idx};
    @(posedge clk);
    conv_valid <= 1'b0;
    repeat (13) @(posedge clk);
  endtask

  // reference crc, msb first, seeded all ones
  function automatic logic [15:0] crc16(input logic [47:0] v);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 47; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'ha2eb : 16'h0000);
    end
    return c;
  endfunction

  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    reset = 1'b1;
    fifo_en = 1'b1;
    stream_mode = 1'b0;
    tag_append_en = 1'b1;
    state_append_en = 1'b0;
    crc_en = 1'b0;
    master_err = 1'b0;
    fifo_clear = 1'b0;
    conv_valid = 1'b0;
    conv = '0;
    watermark = 8'h02;
    int_enable = 7'h02;
    input_limit_enable = 16'h0002;
    upper_limit_value = 12'h800;
    lower_limit_value = 12'h100;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    check("reset status", queue_state, 8'h01);
    check("ready idle", dout, 1'b1);
    master_err <= 1'b1;
    repeat (4) @(posedge clk);
    master_err <= 1'b0;
    repeat (3) @(posedge clk);
    host.frame(`CMD_STAT_RD, 8'h00, 16);
    check("status cmd", host.rx[8:15], 8'h01);
    put(24'h900000, 4'h1);
    put(24'h123456, 4'h2);
    check("level int", fifo_int, 1'b1);
    check("ready full", dout, 1'b0);
    put(24'h0abcde, 4'h3);
    check("status full", queue_state, 8'h56);
    int_enable <= 7'h01;
    repeat (3) @(posedge clk);
    check("int masked", fifo_int, 1'b0);
    int_enable <= 7'h40;
    state_append_en <= 1'b1;
    repeat (3) @(posedge clk);
    check("int werr", fifo_int, 1'b1);
    host.frame(`CMD_FIFO_RD, 8'h02, 80);
    check("status byte", host.rx[8:15], 8'h56);
    check("sample a", host.rx[16:47], {24'h900000, 8'h41});
    check("sample b", host.rx[48:79], {24'h123456, 8'h32});
    repeat (4) @(posedge clk);
    check("after drain", queue_state, 8'h01);
    state_append_en <= 1'b0;
    host.frame(`CMD_FIFO_RD, 8'h01, 48);
    check("empty read", host.rx[16:47], 32'h00000010);
    @(posedge clk);
    tag_append_en <= 1'b0;
    put(24'h654321, 4'h5);
    check("drained off", queue_state.drained, 1'b0);
    host.frame(`CMD_FIFO_RD, 8'h01, 48);
    check("no tag", host.rx[16:47], {24'h654321, 8'h00});
    @(posedge clk);
    tag_append_en <= 1'b1;
    stream_mode <= 1'b1;
    watermark <= 8'h01;
    crc_en <= 1'b1;
    put(24'hc0ffee, 4'h3);
    host.frame(`CMD_FIFO_RD, 8'h01, 64);
    check("crc sample", host.rx[16:47], {24'hc0ffee, 8'h33});
    check("crc", host.rx[48:63], crc16({8'h7d, 8'h01, 24'hc0ffee, 8'h33}));
    // a pop that meets a converter write gets zeros and flags the collision
    @(posedge clk);
    fork
      host.frame(`CMD_FIFO_RD, 8'h01, 48);
      begin
        repeat (66) @(posedge clk);
        conv_valid <= 1'b1;
        conv <= {24'h777777, 4'h4};
        @(posedge clk);
        conv_valid <= 1'b0;
      end
    join
    check("collision data", host.rx[16:47], 32'h0000_0000);
    check("collision flag", queue_state, 8'h22);
    host.frame(`CMD_FIFO_RD, 8'h01, 48);
    check("granted", host.rx[16:47], {24'h777777, 8'h34});
    check("granted flags", queue_state, 8'h01);
    @(posedge clk);
    crc_en <= 1'b0;
    watermark <= 8'h00;
    int_enable <= 7'h02;
    for (int i = 0; i < 257; i++) begin
      put(24'(i), 4'h0);
    end
    check("overrun", queue_state, 8'h06);
    check("full int", fifo_int, 1'b1);
    host.frame(`CMD_FIFO_RD, 8'h01, 40);
    check("oldest gone", host.rx[16:39], 24'h000001);
    @(posedge clk);
    fifo_clear <= 1'b1;
    @(posedge clk);
    fifo_clear <= 1'b0;
    repeat (3) @(posedge clk);
    check("clear", queue_state.lost, 1'b0);
    finish_test;
  end
endmodule
